// file: logic/supply_channel_filter.sv
/*
  Digital noise filter and edge finder for one monitor channel.
  Assumes raw_sync and tick are already in the hclk domain.
*/
`timescale 1ns/1ps
module supply_channel_filter
  import supply_monitor_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic tick,
  input wire logic raw_sync,
  input wire logic filter_en,
  input wire logic [1:0] filter_div,
  output logic level,
  output logic rise,
  output logic fall
);
  logic [FILT_W-1:0] cnt_q;
  logic [FILT_W-1:0] period;
  logic samp_q;
  logic level_q;
  logic level_d;
  logic sample_en;
  logic rise_q;
  logic fall_q;

  assign period = FILT_BASE_TICKS << filter_div;
  assign sample_en = filter_en && tick && (cnt_q == period - 6'h01);

  // Two agreeing samples needed, so one glitch never passes
  always_comb begin
    level_d = level_q;
    if (!filter_en) begin
      level_d = raw_sync;
    end else if (sample_en && samp_q == raw_sync) begin
      level_d = raw_sync;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 6'h00;
      samp_q <= 1'b1;
    end else if (!filter_en) begin
      cnt_q <= 6'h00;
      samp_q <= raw_sync;
    end else if (tick) begin
      cnt_q <= sample_en ? 6'h00 : cnt_q + 6'h01;
      if (sample_en) begin
        samp_q <= raw_sync;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      level_q <= 1'b1;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      level_q <= level_d;
      rise_q <= level_d && !level_q;
      fall_q <= !level_d && level_q;
    end
  end

  assign level = level_q;
  assign rise = rise_q;
  assign fall = fall_q;

  property p_filter_hold;
    @(posedge hclk) disable iff (!hresetn)
    (filter_en && !sample_en) |=> (level_q == $past(level_q));
  endproperty
  a_filter_hold: assert property (p_filter_hold)
    else $error("filtered level moved between samples");
endmodule

// file: logic/supply_monitor_pkg.sv
/*
  Constants, register map and carrier types of the supply monitor.
  Assumes one clock (hclk) and an AHB-Lite master with word accesses.
*/
// Operation
// - Channel 0 holds the processor in reset while the supply is low and frees it a delay after recovery.
// - The channel 0 level comes from a two-bit option field caught once at start-up.
// - Channels 1 and 2 show live whether the supply is above their threshold.
// - Channels 1 and 2 set a crossing flag on a rise or fall through their threshold.
// - Channel 1, when enabled, resets while low and frees after a delay from a rise or from the fall.
// - Channel 2 has the same reset behaviour as channel 1 against its own threshold.
// - A per-channel select sends the channel 1 or 2 interrupt as non-maskable or maskable.
// - The channel 1 or 2 interrupt is raised on fall, rise or both, as set.
// - Channels 1 and 2 have a switchable filter sampling every two divided oscillator cycles.
// - Channels 1 and 2 emit an event pulse on each threshold crossing.
package supply_monitor_pkg;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_CFG1 = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_CFG2 = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h10;
  // Status word layout
  localparam int ST_ABOVE_LSB = 0;
  localparam int ST_CROSS_LSB = 2;
  localparam int ST_RESET_BIT = 4;
  localparam int ST_LVL0_LSB = 8;
  // Interrupt bits: 0 channel 0 reset, 1 and 2 channel requests
  localparam int IRQ_N = 3;
  localparam logic [IRQ_N-1:0] IRQ_MASK_RESET = 3'h0;
  localparam int CFG_W = 12;
  localparam logic [CFG_W-1:0] CFG_RESET = 12'h000;
  localparam int CNT_W = 16;
  // Release delay in oscillator cycles
  localparam logic [CNT_W-1:0] RELEASE_TICKS = 16'h0010;
  // Filter period of two divided cycles at the smallest divider of 2
  localparam int FILT_W = 6;
  localparam logic [FILT_W-1:0] FILT_BASE_TICKS = 6'h04;
  localparam int EDGE_FALL_BIT = 0;
  localparam int EDGE_RISE_BIT = 1;

  typedef struct packed {
    logic [3:0] level_select;
    logic [1:0] filter_div;
    logic filter_en;
    logic [1:0] edge_select;
    logic nmi_select;
    logic release_on_fall;
    logic reset_en;
  } ch_cfg_type;

  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
  } ahb_req_type;

  typedef enum logic [1:0] {
    REL_IDLE,
    REL_HOLD,
    REL_DELAY
  } release_state_type;
endpackage

// file: logic/supply_monitor_top.sv
/*
  Supply monitor control: three reset channels, flags, interrupts and
  events, with an AHB-Lite register slave. Assumes comparator outputs
  and the oscillator pin are asynchronous and a single-master bus.
*/
`timescale 1ns/1ps
module supply_monitor_top
  import supply_monitor_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic low_speed_osc_clock,
  input wire logic [2:0] comp_above,
  input wire logic [1:0] ch0_level_option,
  output logic cpu_reset_n,
  output logic [1:0] ch0_level_select,
  output logic [3:0] ch1_level_select,
  output logic [3:0] ch2_level_select,
  output logic nmi_pulse,
  output logic irq,
  output logic event_ch1,
  output logic event_ch2
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // Synchronisers: first stage read only by the second
  logic [2:0] comp_s1_q;
  logic [2:0] comp_s2_q;
  logic osc_s1_q;
  logic osc_s2_q;
  logic osc_s3_q;
  logic tick;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      comp_s1_q <= 3'h7;
      comp_s2_q <= 3'h7;
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
    end else begin
      comp_s1_q <= comp_above;
      comp_s2_q <= comp_s1_q;
      osc_s1_q <= low_speed_osc_clock;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
    end
  end

  // One pulse per oscillator cycle
  assign tick = osc_s2_q && !osc_s3_q;

  // Option field caught once, one cycle after release
  logic strap_done_q;
  logic [1:0] lvl0_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_done_q <= 1'b0;
      lvl0_q <= 2'h0;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      lvl0_q <= ch0_level_option;
    end
  end

  // Register state
  ch_cfg_type cfg_q [1:2];
  logic [1:0] cross_q;
  logic [IRQ_N-1:0] irq_stat_q;
  logic [IRQ_N-1:0] irq_mask_q;
  logic [IRQ_N-1:0] irq_set;

  // Per-channel level and edges, filtered on channels 1 and 2
  logic [2:0] above;
  logic [2:0] rise;
  logic [2:0] fall;
  logic [2:0] req;
  logic [1:0] event_q;

  assign above[0] = comp_s2_q[0];
  assign rise[0] = 1'b0;
  assign fall[0] = 1'b0;
  assign req[0] = 1'b0;

  genvar i;
  generate
    for (i = 1; i <= 2; i++) begin : g_ch
      supply_channel_filter u_filt (
        .hclk(hclk),
        .hresetn(hresetn),
        .tick(tick),
        .raw_sync(comp_s2_q[i]),
        .filter_en(cfg_q[i].filter_en),
        .filter_div(cfg_q[i].filter_div),
        .level(above[i]),
        .rise(rise[i]),
        .fall(fall[i])
      );

      // Edge choice per channel
      assign req[i] = (rise[i] && cfg_q[i].edge_select[EDGE_RISE_BIT])
        || (fall[i] && cfg_q[i].edge_select[EDGE_FALL_BIT]);

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          event_q[i-1] <= 1'b0;
        end else begin
          event_q[i-1] <= rise[i] || fall[i];
        end
      end

      property p_cross_set;
        (rise[i] || fall[i]) |=> cross_q[i-1];
      endproperty
      a_cross_set: assert property (p_cross_set)
        else $error("crossing flag not set");

      property p_event;
        (rise[i] || fall[i]) |=> event_q[i-1] ##1 !event_q[i-1];
      endproperty
      a_event: assert property (p_event)
        else $error("event pulse missing or too long");

      property p_req_latch;
        req[i] |=> irq_stat_q[i];
      endproperty
      a_req_latch: assert property (p_req_latch)
        else $error("interrupt request lost");

      sequence s_nmi_req;
        req[i] && cfg_q[i].nmi_select;
      endsequence
      property p_nmi_type;
        s_nmi_req |=> nmi_pulse;
      endproperty
      a_nmi_type: assert property (p_nmi_type)
        else $error("non-maskable request not issued");

      property p_live_flag;
        !cfg_q[i].filter_en && $stable(cfg_q[i].filter_en) [*2]
          |-> above[i] == $past(comp_s2_q[i]);
      endproperty
      a_live_flag: assert property (p_live_flag)
        else $error("live flag does not follow comparator");
    end
  endgenerate

  // Reset release per channel; channel 0 always enabled
  release_state_type rel_q [0:2];
  logic [CNT_W-1:0] rel_cnt_q [0:2];
  logic [2:0] rel_en;
  logic [2:0] rel_on_fall;
  logic [2:0] held;
  logic ch0_entry;

  assign rel_en = {cfg_q[2].reset_en, cfg_q[1].reset_en, 1'b1};
  assign rel_on_fall = {cfg_q[2].release_on_fall,
    cfg_q[1].release_on_fall, 1'b0};

  generate
    for (i = 0; i <= 2; i++) begin : g_rel
      assign held[i] = rel_q[i] != REL_IDLE;

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          rel_q[i] <= (i == 0) ? REL_HOLD : REL_IDLE;
          rel_cnt_q[i] <= 16'h0000;
        end else begin
          case (rel_q[i])
            REL_IDLE: begin
              rel_cnt_q[i] <= 16'h0000;
              if (rel_en[i] && rel_on_fall[i] && fall[i]) begin
                rel_q[i] <= REL_DELAY;
              end else if (rel_en[i] && !rel_on_fall[i] && !above[i]) begin
                rel_q[i] <= REL_HOLD;
              end
            end
            REL_HOLD: begin
              rel_cnt_q[i] <= 16'h0000;
              if (!rel_en[i]) begin
                rel_q[i] <= REL_IDLE;
              end else if (above[i] || rel_on_fall[i]) begin
                rel_q[i] <= REL_DELAY;
              end
            end
            REL_DELAY: begin
              if (!rel_en[i]) begin
                rel_q[i] <= REL_IDLE;
              end else if (!rel_on_fall[i] && !above[i]) begin
                rel_q[i] <= REL_HOLD;
              end else if (tick) begin
                // Delay counted in oscillator cycles
                if (rel_cnt_q[i] == RELEASE_TICKS - 16'h0001) begin
                  rel_q[i] <= REL_IDLE;
                end else begin
                  rel_cnt_q[i] <= rel_cnt_q[i] + 16'h0001;
                end
              end
            end
            default: begin
              rel_q[i] <= REL_IDLE;
            end
          endcase
        end
      end
    end
  endgenerate

  assign ch0_entry = rel_q[0] == REL_IDLE && !above[0];

  // Outputs and interrupt line
  logic cpu_reset_n_q;
  logic nmi_q;
  logic irq_q;
  logic [1:0] nmi_sel;

  assign nmi_sel = {cfg_q[2].nmi_select, cfg_q[1].nmi_select};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cpu_reset_n_q <= 1'b0;
      nmi_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      cpu_reset_n_q <= !(|held);
      nmi_q <= |(req[2:1] & nmi_sel);
      // Non-maskable sources stay off the ordinary line
      irq_q <= |(irq_stat_q & irq_mask_q & {~nmi_sel, 1'b1});
    end
  end

  // Bus slave: zero wait states, always OKAY
  ahb_req_type req_q;
  logic wr_pend_q;
  logic [31:0] hrdata_q;
  logic addr_ok;
  logic rd_take;
  logic rd_stat;
  logic [31:0] rd_mux;
  logic [31:0] status_word;

  assign addr_ok = hsel && hready && htrans[1];
  assign rd_take = addr_ok && !hwrite;
  assign rd_stat = rd_take && haddr[ADDR_W-1:0] == ADDR_IRQ_STAT;

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[ST_ABOVE_LSB +: 2] = above[2:1];
    status_word[ST_CROSS_LSB +: 2] = cross_q;
    status_word[ST_RESET_BIT] = !cpu_reset_n_q;
    status_word[ST_LVL0_LSB +: 2] = lvl0_q;
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (haddr[ADDR_W-1:0] == ADDR_CFG1) begin
      rd_mux[CFG_W-1:0] = cfg_q[1];
    end else if (haddr[ADDR_W-1:0] == ADDR_CFG2) begin
      rd_mux[CFG_W-1:0] = cfg_q[2];
    end else if (haddr[ADDR_W-1:0] == ADDR_STATUS) begin
      rd_mux = status_word;
    end else if (haddr[ADDR_W-1:0] == ADDR_IRQ_STAT) begin
      rd_mux[IRQ_N-1:0] = irq_stat_q;
    end else if (haddr[ADDR_W-1:0] == ADDR_IRQ_MASK) begin
      rd_mux[IRQ_N-1:0] = irq_mask_q;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_q <= '0;
      wr_pend_q <= 1'b0;
      hrdata_q <= 32'h0000_0000;
    end else begin
      wr_pend_q <= addr_ok && hwrite;
      if (addr_ok) begin
        req_q <= '{write: hwrite, addr: haddr[ADDR_W-1:0]};
      end
      if (rd_take) begin
        hrdata_q <= rd_mux;
      end
    end
  end

  // Writes land at the end of the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_q[1] <= CFG_RESET;
      cfg_q[2] <= CFG_RESET;
      irq_mask_q <= IRQ_MASK_RESET;
    end else if (wr_pend_q) begin
      if (req_q.addr == ADDR_CFG1) begin
        cfg_q[1] <= hwdata[CFG_W-1:0];
      end else if (req_q.addr == ADDR_CFG2) begin
        cfg_q[2] <= hwdata[CFG_W-1:0];
      end else if (req_q.addr == ADDR_IRQ_MASK) begin
        irq_mask_q <= hwdata[IRQ_N-1:0];
      end
    end
  end

  // Sticky flags: a new event beats a clear in the same cycle
  logic [1:0] cross_clr;
  assign cross_clr = (wr_pend_q && req_q.addr == ADDR_STATUS) ?
    hwdata[ST_CROSS_LSB +: 2] : 2'h0;
  assign irq_set = {req[2:1], ch0_entry};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cross_q <= 2'h0;
      irq_stat_q <= 3'h0;
    end else begin
      cross_q <= (cross_q & ~cross_clr) | (rise[2:1] | fall[2:1]);
      irq_stat_q <= (rd_stat ? 3'h0 : irq_stat_q) | irq_set;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign cpu_reset_n = cpu_reset_n_q;
  assign ch0_level_select = lvl0_q;
  assign ch1_level_select = cfg_q[1].level_select;
  assign ch2_level_select = cfg_q[2].level_select;
  assign nmi_pulse = nmi_q;
  assign irq = irq_q;
  assign event_ch1 = event_q[0];
  assign event_ch2 = event_q[1];

  property p_ch0_hold;
    !comp_s2_q[0] |-> ##2 !cpu_reset_n_q;
  endproperty
  a_ch0_hold: assert property (p_ch0_hold)
    else $error("reset not held while supply low");

  property p_ch1_hold;
    (cfg_q[1].reset_en && !cfg_q[1].release_on_fall && !above[1])
      |-> ##2 !cpu_reset_n_q;
  endproperty
  a_ch1_hold: assert property (p_ch1_hold)
    else $error("channel 1 reset not held");

  property p_ch2_hold;
    (cfg_q[2].reset_en && !cfg_q[2].release_on_fall && !above[2])
      |-> ##2 !cpu_reset_n_q;
  endproperty
  a_ch2_hold: assert property (p_ch2_hold)
    else $error("channel 2 reset not held");

  sequence s_last_tick;
    rel_q[0] == REL_DELAY && above[0] && tick
      && rel_cnt_q[0] == RELEASE_TICKS - 16'h0001;
  endsequence
  property p_delay_end;
    s_last_tick |=> rel_q[0] == REL_IDLE;
  endproperty
  a_delay_end: assert property (p_delay_end)
    else $error("release delay miscounted");

  property p_early;
    (rel_q[0] == REL_DELAY && rel_cnt_q[0] != RELEASE_TICKS - 16'h0001)
      |=> rel_q[0] != REL_IDLE;
  endproperty
  a_early: assert property (p_early)
    else $error("channel 0 released before the delay");

  property p_strap;
    strap_done_q |=> $stable(lvl0_q);
  endproperty
  a_strap: assert property (p_strap)
    else $error("channel 0 level changed after start-up");

  property p_cross_sticky;
    (cross_q[0] && !cross_clr[0]) |=> cross_q[0];
  endproperty
  a_cross_sticky: assert property (p_cross_sticky)
    else $error("crossing flag dropped without clear");
endmodule

// file: verif/supply_comparator_model.sv
/*
  Behavioural comparators on the supply rail, one for each channel.
  Assumes the bench sets the target levels by NBA after a rising hclk edge.
*/
`timescale 1ns/1ps
module supply_comparator_model (
  input wire logic hclk,
  input wire logic [2:0] target,
  input wire logic [3:0] bounce_len,
  output logic [2:0] comp_above
);
  logic [2:0] last_q = 3'h7;
  logic [2:0] chg_q = 3'h0;
  logic [3:0] bounce_q = 4'h0;
  logic [2:0] out_q = 3'h7;
  assign comp_above = out_q;
  // Real comparators chatter near the threshold, so a change may bounce first
  // Only the channel that moved chatters; the others stay quiet
  always @(posedge hclk) begin
    if (target != last_q) begin
      bounce_q <= bounce_len;
      chg_q <= target ^ last_q;
    end else if (bounce_q != 4'h0) begin
      bounce_q <= bounce_q - 4'h1;
    end
    last_q <= target;
    out_q <= bounce_q[0] ? target ^ chg_q : target;
  end
endmodule

// file: verif/supply_monitor_logic_tb.sv
/*
  Self-checking bench of the supply monitor: AHB-Lite master tasks,
  oscillator at hclk/8 and the comparator model. Assumes hready = hreadyout.
*/
`timescale 1ns/1ps
module supply_monitor_logic_tb
  import supply_monitor_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, cpu_reset_n, nmi_pulse, irq;
  logic [31:0] haddr, hwdata, hrdata, x;
  logic [1:0] htrans, opt, l0;
  logic [2:0] hsize, osc_q, tgt, comp;
  logic [3:0] blen, l1, l2;
  logic ev_ch1, ev_ch2;
  int n_errors, total_checks, n, p, e, m;
  int ev[3];
  int nm;
  localparam int T = 8 * int'(RELEASE_TICKS);
  logic [11:0] cf[4] = '{12'h008, 12'h010, 12'h01c, 12'h018};
  logic [2:0] mk[4] = '{3'h6, 3'h6, 3'h6, 3'h0};

  supply_comparator_model u_cmp (.hclk(hclk), .target(tgt), .bounce_len(blen),
    .comp_above(comp));
  supply_monitor_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .low_speed_osc_clock(osc_q[2]),
    .comp_above(comp), .ch0_level_option(opt), .cpu_reset_n(cpu_reset_n),
    .ch0_level_select(l0), .ch1_level_select(l1), .ch2_level_select(l2),
    .nmi_pulse(nmi_pulse), .irq(irq), .event_ch1(ev_ch1), .event_ch2(ev_ch2));

  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    osc_q <= osc_q + 3'h1;
    if (ev_ch1 === 1'b1) ev[1]++;
    if (ev_ch2 === 1'b1) ev[2]++;
    if (nmi_pulse === 1'b1) nm++;
  end

  task stop_test;
    if (n_errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task rng(input int v, input int lo, input int hi);
    chk({31'h0, v >= lo && v <= hi}, 32'h1);
  endtask
  // One single transfer; the address phase is held until hready is seen high
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    x = hrdata;
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] msk);
    bus(1'b0, a, 32'h0);
    chk(x & msk, exp);
  endtask
  task set_c(input int ch, input logic v);
    @(posedge hclk);
    tgt[ch] <= v;
  endtask
  task wait_rn(input logic v);
    n = 0;
    while (cpu_reset_n !== v && n < 3000) begin
      @(negedge hclk);
      n++;
    end
  endtask
  task cyc(input int k);
    repeat (k) @(negedge hclk);
  endtask

  task t_boot;
    @(negedge hclk);
    chk(cpu_reset_n, 1'b0);
    wait_rn(1'b1);
    rng(n, T - 12, T + 24);
    chk(l0, 2'h2);
    chk(hresp, 1'b0);
    rdc(ADDR_STATUS, 32'h200, 32'h310);
    rdc(ADDR_IRQ_MASK, 32'h0, 32'hffffffff);
    bus(1'b0, ADDR_IRQ_STAT, 32'h0);
  endtask
  task t_ch0;
    set_c(0, 1'b0);
    wait_rn(1'b0);
    rng(n, 1, 8);
    rdc(ADDR_IRQ_STAT, 32'h1, 32'h1);
    cyc(200);
    chk(cpu_reset_n, 1'b0);
    set_c(0, 1'b1);
    wait_rn(1'b1);
    rng(n, T - 12, T + 24);
  endtask
  task t_flags;
    rdc(8'h20, 32'h0, 32'hffffffff);
    for (int ch = 1; ch <= 2; ch++) begin
      bus(1'b1, 8'((ch - 1) * 4), 32'ha18);
      cyc(1);
      chk(ch == 1 ? l1 : l2, 4'ha);
      rdc(8'((ch - 1) * 4), 32'ha18, 32'hfff);
      e = ev[ch];
      p = (3 & ~(1 << (ch - 1))) | (1 << (ch + 1));
      set_c(ch, 1'b0);
      cyc(10);
      rdc(ADDR_STATUS, p, 32'hf);
      chk(ev[ch], e + 1);
      cyc(60);
      rdc(ADDR_STATUS, p, 32'hf);
      bus(1'b1, ADDR_STATUS, 32'hc);
      rdc(ADDR_STATUS, p & 3, 32'hf);
      set_c(ch, 1'b1);
      cyc(10);
      rdc(ADDR_STATUS, 32'h3 | (1 << (ch + 1)), 32'hf);
      chk(ev[ch], e + 2);
      bus(1'b1, ADDR_STATUS, 32'hc);
    end
  endtask
  task t_reset;
    for (int ch = 1; ch <= 2; ch++) begin
      bus(1'b1, 8'((ch - 1) * 4), 32'h1);
      set_c(ch, 1'b0);
      wait_rn(1'b0);
      rng(n, 1, 10);
      cyc(300);
      rdc(ADDR_STATUS, 32'h10, 32'h10);
      set_c(ch, 1'b1);
      wait_rn(1'b1);
      rng(n, T - 12, T + 24);
      bus(1'b1, 8'((ch - 1) * 4), 32'h3);
      set_c(ch, 1'b0);
      wait_rn(1'b0);
      rng(n, 1, 10);
      wait_rn(1'b1);
      rng(n, T - 12, T + 24);
      set_c(ch, 1'b1);
      cyc(20);
      chk(cpu_reset_n, 1'b1);
      bus(1'b1, 8'((ch - 1) * 4), 32'h0);
      bus(1'b1, ADDR_STATUS, 32'hc);
    end
  endtask
  task t_irq;
    for (int ch = 1; ch <= 2; ch++) begin
      for (int k = 0; k < 4; k++) begin
        bus(1'b1, 8'((ch - 1) * 4), {20'h0, cf[k]});
        bus(1'b1, ADDR_IRQ_MASK, {29'h0, mk[k]});
        bus(1'b0, ADDR_IRQ_STAT, 32'h0);
        m = nm;
        set_c(ch, 1'b0);
        cyc(10);
        chk(irq, cf[k][3] & ~cf[k][2] & mk[k][ch]);
        bus(1'b0, ADDR_IRQ_STAT, 32'h0);
        if (!cf[k][2]) chk(x[ch], cf[k][3]);
        cyc(4);
        chk(irq, 1'b0);
        set_c(ch, 1'b1);
        cyc(10);
        chk(irq, cf[k][4] & ~cf[k][2] & mk[k][ch]);
        bus(1'b0, ADDR_IRQ_STAT, 32'h0);
        if (!cf[k][2]) chk(x[ch], cf[k][4]);
        chk(nm - m, cf[k][2] ? 2 : 0);
      end
      bus(1'b1, 8'((ch - 1) * 4), 32'h0);
    end
  endtask
  // Short glitches under one sample period must not pass; long lows must
  task t_filter;
    blen <= 4'h7;
    for (int d = 0; d < 4; d++) begin
      p = 32 << d;
      bus(1'b1, ADDR_CFG1, 32'h38 | (d << 6));
      e = ev[1];
      set_c(1, 1'b0);
      cyc(p - 12);
      set_c(1, 1'b1);
      cyc(2 * p);
      chk(ev[1], e);
      rdc(ADDR_STATUS, 32'h1, 32'h1);
      set_c(1, 1'b0);
      cyc(3 * p + 16);
      rdc(ADDR_STATUS, 32'h0, 32'h1);
      set_c(1, 1'b1);
      cyc(3 * p + 16);
      chk(ev[1], e + 2);
    end
    blen <= 4'h0;
    bus(1'b1, ADDR_CFG1, 32'h18);
    e = ev[1];
    set_c(1, 1'b0);
    cyc(6);
    set_c(1, 1'b1);
    cyc(10);
    chk(ev[1], e + 2);
  endtask

  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, osc_q, blen} = '0;
    hsize = 3'h2;
    tgt = 3'h7;
    opt = 2'h2;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_boot();
    t_ch0();
    t_flags();
    t_reset();
    t_irq();
    t_filter();
    stop_test();
  end
  initial begin
    repeat (60000) @(posedge hclk);
    n_errors++;
    stop_test();
  end
endmodule
